// [hdl/etq_pkg.sv]
// Purpose: constants and types for the external trigger qualifier
// Assumes: 200 MHz core clock
// Notes:   register map, field layout, reset values, timing counts
package etq_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int NS_PER_US     = 1000;
    localparam int US_PER_MS     = 1000;
    localparam int US_CYCLES     = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  US_LAST  = 8'(US_CYCLES - 1);
    localparam logic [9:0]  MS_LAST  = 10'(US_PER_MS - 1);
    localparam logic [31:0] NS_STEP  = 32'(CLK_PERIOD_NS);
    localparam logic [31:0] UNIT_STEP = 32'h0000_0001;

    localparam int FRAME_W = 18;
    localparam int IGN_W   = 27;
    localparam int PIN_N   = 8;
    localparam int FV_BIT  = PIN_N;
    localparam logic [31:0] FRAME_MAX = 32'h0003_FFFE;

    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_MINW   = 8'h04;
    localparam logic [7:0] ADR_FRAMES = 8'h08;
    localparam logic [7:0] ADR_DELAY  = 8'h0C;
    localparam logic [7:0] ADR_IGNORE = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;
    localparam logic [7:0] ADR_DONE   = 8'h18;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_SEL_LSB  = 3;
    localparam int CTRL_TB_LSB   = 6;
    localparam int ST_STATE_LSB  = 1;
    localparam int ST_ACQ_BIT    = 4;
    localparam int ST_IGN_BIT    = 5;
    localparam int ST_REJ_BIT    = 8;

    localparam logic [2:0]         SEL_RESET    = 3'h0;
    localparam logic [FRAME_W-1:0] FRAMES_RESET = 18'h0_0001;

    typedef enum logic [1:0] {
        ETQ_RISE = 2'h0, ETQ_FALL = 2'h1, ETQ_LOW = 2'h2, ETQ_HIGH = 2'h3
    } etq_mode_e;

    typedef enum logic [2:0] {
        ETQ_TB_NS = 3'h0, ETQ_TB_US = 3'h1, ETQ_TB_MS = 3'h2, ETQ_TB_LINE = 3'h3,
        ETQ_TB_LTRIG = 3'h4, ETQ_TB_ENC = 3'h5, ETQ_TB_FRAME = 3'h6
    } etq_tb_e;

    typedef enum logic [1:0] {
        ETQ_IDLE = 2'h0, ETQ_QUAL = 2'h1, ETQ_DELAY = 2'h3, ETQ_ACQ = 2'h2
    } etq_state_e;
endpackage : etq_pkg

// [hdl/etq_trigger_qualifier.sv]
// Purpose: qualifies an external frame trigger and requests frame capture
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes:   all state in one struct, registered once per enabled cycle
`timescale 1ns/100ps
`default_nettype none

// Operation
// - enabled: capture only after a qualified trigger; disabled: trigger inputs do nothing
// - level mode: capture continuously while input active, stop when it returns
// - edge mode: each selected transition starts one capture sequence
// - each accepted edge-mode trigger captures a programmed 1 to 262142 frames
// - no unlimited count; -1 or out-of-range count is rejected
// - pulse width measured in microseconds; shorter than minimum is discarded
// - minimum width zero turns width checking off
// - wait programmed delay after acceptance before capture starts
// - delay unit: ns, us, ms, lines, line triggers, encoder, frames
// - line trigger and encoder delays count post drop/multiply pulses
// - triggers inside the ignore window (0 to 134217727 us) are ignored
// - ignore window starts at first frame valid rise after acceptance
// - trigger taken from a software-selected input, default board sync one
module etq_trigger_qualifier (
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    ce_in,
    input  wire logic                    wb_cyc_in,
    input  wire logic                    wb_stb_in,
    input  wire logic                    wb_we_in,
    input  wire logic [7:0]              wb_adr_in,
    input  wire logic [3:0]              wb_sel_in,
    input  wire logic [31:0]             wb_dat_in,
    output var  logic [31:0]             wb_dat_out,
    output var  logic                    wb_ack_out,
    input  wire logic [etq_pkg::PIN_N-1:0] trig_pins_in,
    input  wire logic                    frame_valid_in,
    input  wire logic                    line_pulse_in,
    input  wire logic                    line_trig_pulse_in,
    input  wire logic                    encoder_pulse_in,
    output var  logic                    acq_req_out,
    output var  logic                    trig_accept_out
);

    typedef struct packed {
        logic [etq_pkg::PIN_N:0]       s1;
        logic [etq_pkg::PIN_N:0]       s2;
        logic [etq_pkg::PIN_N:0]       s3;
        logic [etq_pkg::PIN_N:0]       filt;
        logic [etq_pkg::PIN_N:0]       filt_prev;
        logic                          en;
        etq_pkg::etq_mode_e            mode;
        logic [2:0]                    sel;
        logic [2:0]                    tb;
        logic [31:0]                   min_width;
        logic [etq_pkg::FRAME_W-1:0]   frames;
        logic [31:0]                   delay;
        logic [etq_pkg::IGN_W-1:0]     ign_cfg;
        logic                          reject;
        etq_pkg::etq_state_e           state;
        logic [7:0]                    div_cyc;
        logic [9:0]                    div_ms;
        logic [31:0]                   width_us;
        logic [31:0]                   dly_rem;
        logic [etq_pkg::FRAME_W-1:0]   done;
        logic                          ign_wait;
        logic [etq_pkg::IGN_W-1:0]     ign_rem;
        logic                          acq;
        logic                          accept;
        logic                          ack;
        logic [31:0]                   rdat;
    } etq_state_s;

    etq_state_s st;
    etq_state_s next_st;

    function automatic logic [31:0] etq_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : etq_merge

    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic        pin;
    logic        pin_prev;
    logic        inv;
    logic        act;
    logic        act_prev;
    logic        fv_rise;
    logic        fv_fall;
    logic        us_tick;
    logic        ms_tick;
    logic        ev;
    logic [31:0] step;
    logic        take;
    logic        is_level;
    logic        ign_busy;
    logic [31:0] wval;
    logic [31:0] next_width;
    logic [etq_pkg::FRAME_W-1:0] next_done;

    always_comb begin
        ctrl_word = '0;
        ctrl_word[etq_pkg::CTRL_EN_BIT] = st.en;
        ctrl_word[etq_pkg::CTRL_MODE_LSB +: 2] = st.mode;
        ctrl_word[etq_pkg::CTRL_SEL_LSB +: 3] = st.sel;
        ctrl_word[etq_pkg::CTRL_TB_LSB +: 3] = st.tb;
        status_word = '0;
        status_word[etq_pkg::CTRL_EN_BIT] = st.en;
        status_word[etq_pkg::ST_STATE_LSB +: 2] = st.state;
        status_word[etq_pkg::ST_ACQ_BIT] = st.acq;
        status_word[etq_pkg::ST_IGN_BIT] = st.ign_wait | (st.ign_rem != '0);
        status_word[etq_pkg::ST_REJ_BIT] = st.reject;
    end

    always_comb begin
        next_st = st;
        next_st.accept = 1'b0;
        next_st.ack = 1'b0;
        take = 1'b0;
        wval = '0;
        // three-stage input sync, change counted once stages two and three agree
        next_st.s1 = {frame_valid_in, trig_pins_in};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = (st.s2 & ~(st.s2 ^ st.s3)) | (st.filt & (st.s2 ^ st.s3));
        next_st.filt_prev = st.filt;

        pin = st.filt[st.sel];
        pin_prev = st.filt_prev[st.sel];
        inv = (st.mode == etq_pkg::ETQ_FALL) || (st.mode == etq_pkg::ETQ_LOW);
        is_level = (st.mode == etq_pkg::ETQ_LOW) || (st.mode == etq_pkg::ETQ_HIGH);
        act = pin ^ inv;
        act_prev = pin_prev ^ inv;
        fv_rise = st.filt[etq_pkg::FV_BIT] & ~st.filt_prev[etq_pkg::FV_BIT];
        fv_fall = ~st.filt[etq_pkg::FV_BIT] & st.filt_prev[etq_pkg::FV_BIT];

        // microsecond and millisecond prescaler
        us_tick = (st.div_cyc == etq_pkg::US_LAST);
        ms_tick = us_tick && (st.div_ms == etq_pkg::MS_LAST);
        next_st.div_cyc = us_tick ? '0 : st.div_cyc + 8'h01;
        if (us_tick) begin
            next_st.div_ms = ms_tick ? '0 : st.div_ms + 10'h001;
        end

        // delay unit events
        step = etq_pkg::UNIT_STEP;
        unique case (etq_pkg::etq_tb_e'(st.tb))
            etq_pkg::ETQ_TB_NS: begin
                ev = 1'b1;
                step = etq_pkg::NS_STEP;
            end
            etq_pkg::ETQ_TB_US:    ev = us_tick;
            etq_pkg::ETQ_TB_MS:    ev = ms_tick;
            etq_pkg::ETQ_TB_LINE:  ev = line_pulse_in;
            etq_pkg::ETQ_TB_LTRIG: ev = line_trig_pulse_in;
            etq_pkg::ETQ_TB_ENC:   ev = encoder_pulse_in;
            etq_pkg::ETQ_TB_FRAME: ev = fv_rise;
            default:               ev = 1'b0;
        endcase

        // ignore window, timed from first frame valid rise after acceptance
        ign_busy = st.ign_wait | (st.ign_rem != '0);
        if (st.ign_wait && fv_rise) begin
            next_st.ign_wait = 1'b0;
            next_st.ign_rem = st.ign_cfg;
        end else if (st.ign_rem != '0 && us_tick) begin
            next_st.ign_rem = st.ign_rem - 27'h1;
        end

        next_width = st.width_us + 32'h1;
        next_done = st.done + 18'h1;
        unique case (st.state)
            etq_pkg::ETQ_IDLE: begin
                if (st.en && !ign_busy && act && (is_level || !act_prev)) begin
                    next_st.div_cyc = '0;
                    next_st.div_ms = '0;
                    next_st.width_us = '0;
                    if (st.min_width == '0) begin
                        take = 1'b1;
                    end else begin
                        next_st.state = etq_pkg::ETQ_QUAL;
                    end
                end
            end
            etq_pkg::ETQ_QUAL: begin
                if (!act) begin
                    next_st.state = etq_pkg::ETQ_IDLE;
                end else if (us_tick) begin
                    next_st.width_us = next_width;
                    if (next_width >= st.min_width) begin
                        take = 1'b1;
                    end
                end
            end
            etq_pkg::ETQ_DELAY: begin
                if (is_level && !act) begin
                    next_st.state = etq_pkg::ETQ_IDLE;
                    next_st.ign_wait = 1'b0;
                end else if (ev) begin
                    if (st.dly_rem <= step) begin
                        next_st.state = etq_pkg::ETQ_ACQ;
                        next_st.acq = 1'b1;
                    end else begin
                        next_st.dly_rem = st.dly_rem - step;
                    end
                end
            end
            etq_pkg::ETQ_ACQ: begin
                if (is_level) begin
                    if (!act) begin
                        next_st.acq = 1'b0;
                        next_st.state = etq_pkg::ETQ_IDLE;
                        next_st.ign_wait = 1'b0;
                    end
                end else if (fv_fall) begin
                    next_st.done = next_done;
                    if (next_done >= st.frames) begin
                        next_st.acq = 1'b0;
                        next_st.state = etq_pkg::ETQ_IDLE;
                    end
                end
            end
        endcase

        if (take) begin
            next_st.accept = 1'b1;
            next_st.ign_wait = 1'b1;
            next_st.done = '0;
            next_st.dly_rem = st.delay;
            next_st.div_cyc = '0;
            next_st.div_ms = '0;
            if (st.delay == '0) begin
                next_st.state = etq_pkg::ETQ_ACQ;
                next_st.acq = 1'b1;
            end else begin
                next_st.state = etq_pkg::ETQ_DELAY;
            end
        end

        if (!st.en) begin
            next_st.state = etq_pkg::ETQ_IDLE;
            next_st.acq = 1'b0;
            next_st.accept = 1'b0;
            next_st.ign_wait = 1'b0;
            next_st.ign_rem = '0;
        end

        // wishbone classic slave, one wait state, unmapped reads zero
        if (wb_cyc_in && wb_stb_in && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdat = '0;
            if (wb_we_in) begin
                unique case (wb_adr_in)
                    etq_pkg::ADR_CTRL: begin
                        wval = etq_merge(ctrl_word, wb_dat_in, wb_sel_in);
                        next_st.en = wval[etq_pkg::CTRL_EN_BIT];
                        next_st.mode = etq_pkg::etq_mode_e'(wval[etq_pkg::CTRL_MODE_LSB +: 2]);
                        next_st.sel = wval[etq_pkg::CTRL_SEL_LSB +: 3];
                        next_st.tb = wval[etq_pkg::CTRL_TB_LSB +: 3];
                    end
                    etq_pkg::ADR_MINW: begin
                        next_st.min_width = etq_merge(st.min_width, wb_dat_in, wb_sel_in);
                    end
                    etq_pkg::ADR_FRAMES: begin
                        wval = etq_merge(32'(st.frames), wb_dat_in, wb_sel_in);
                        if (wval == '0 || wval > etq_pkg::FRAME_MAX) begin
                            next_st.reject = 1'b1;
                        end else begin
                            next_st.frames = wval[etq_pkg::FRAME_W-1:0];
                        end
                    end
                    etq_pkg::ADR_DELAY: begin
                        next_st.delay = etq_merge(st.delay, wb_dat_in, wb_sel_in);
                    end
                    etq_pkg::ADR_IGNORE: begin
                        wval = etq_merge(32'(st.ign_cfg), wb_dat_in, wb_sel_in);
                        next_st.ign_cfg = wval[etq_pkg::IGN_W-1:0];
                    end
                    etq_pkg::ADR_STATUS: begin
                        if (wb_sel_in[1] && wb_dat_in[etq_pkg::ST_REJ_BIT]) begin
                            next_st.reject = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (wb_adr_in)
                    etq_pkg::ADR_CTRL:   next_st.rdat = ctrl_word;
                    etq_pkg::ADR_MINW:   next_st.rdat = st.min_width;
                    etq_pkg::ADR_FRAMES: next_st.rdat = 32'(st.frames);
                    etq_pkg::ADR_DELAY:  next_st.rdat = st.delay;
                    etq_pkg::ADR_IGNORE: next_st.rdat = 32'(st.ign_cfg);
                    etq_pkg::ADR_STATUS: next_st.rdat = status_word;
                    etq_pkg::ADR_DONE:   next_st.rdat = 32'(st.done);
                    default:             next_st.rdat = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st <= '0;
            st.mode <= etq_pkg::ETQ_RISE;
            st.sel <= etq_pkg::SEL_RESET;
            st.tb <= etq_pkg::ETQ_TB_NS;
            st.frames <= etq_pkg::FRAMES_RESET;
            st.state <= etq_pkg::ETQ_IDLE;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign wb_dat_out = st.rdat;
    assign wb_ack_out = st.ack;
    assign acq_req_out = st.acq;
    assign trig_accept_out = st.accept;

endmodule : etq_trigger_qualifier
`default_nettype wire

// [tb/etq_props.sv]
// Purpose: port assertions for the trigger qualifier
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the qualifier, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module etq_props (
    input wire logic                        clk_in,
    input wire logic                        reset_in,
    input wire logic                        ce_in,
    input wire logic                        wb_cyc_in,
    input wire logic                        wb_stb_in,
    input wire logic                        wb_we_in,
    input wire logic [7:0]                  wb_adr_in,
    input wire logic [3:0]                  wb_sel_in,
    input wire logic [31:0]                 wb_dat_in,
    input wire logic [31:0]                 wb_dat_out,
    input wire logic                        wb_ack_out,
    input wire logic [etq_pkg::PIN_N-1:0]   trig_pins_in,
    input wire logic                        frame_valid_in,
    input wire logic                        line_pulse_in,
    input wire logic                        line_trig_pulse_in,
    input wire logic                        encoder_pulse_in,
    input wire logic                        acq_req_out,
    input wire logic                        trig_accept_out
);
    typedef struct packed {
        logic en;
        logic armed;
    } etq_chk_s;
    etq_chk_s st;
    etq_chk_s next_st;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // shadow of the enable bit and a pending-start flag
    always_comb begin
        next_st = st;
        if (ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0]
            && wb_adr_in == etq_pkg::ADR_CTRL) next_st.en = wb_dat_in[etq_pkg::CTRL_EN_BIT];
        if (trig_accept_out) next_st.armed = 1'b1;
        else if (acq_req_out) next_st.armed = 1'b0;
        if (reset_in) next_st = '0;
    end
    always_ff @(posedge clk_in) st <= next_st;
    a_accept_pulse: assert property (trig_accept_out && ce_in |=> !trig_accept_out)
        else $error("accept pulse longer than one cycle");
    a_start_needs_accept: assert property ($rose(acq_req_out) |-> st.armed || trig_accept_out)
        else $error("capture started without an accepted trigger");
    a_disabled_quiet: assert property (!st.en && !$past(st.en) |-> !trig_accept_out)
        else $error("trigger accepted while disabled");
    a_accept_idle_only: assert property (trig_accept_out && $past(ce_in) |-> !$past(acq_req_out))
        else $error("trigger accepted during capture");
    a_ce_freeze: assert property (!ce_in |=> $stable(acq_req_out) && $stable(trig_accept_out))
        else $error("outputs moved while clock enable low");
    a_reset_clears: assert property (disable iff (1'b0)
        reset_in && ce_in |=> !acq_req_out && !trig_accept_out && !wb_ack_out)
        else $error("outputs active after reset");
    a_ack_answers: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
        else $error("bus request not acknowledged next cycle");
    a_ack_single: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property ($rose(wb_ack_out) |-> $past(wb_stb_in))
        else $error("ack without a request");
    c_accept: cover property (trig_accept_out);
    c_capture_end: cover property ($fell(acq_req_out));
    c_frozen_capture: cover property (!ce_in && acq_req_out);
endmodule : etq_props
bind etq_trigger_qualifier etq_props etq_props_i (
    .clk_in, .reset_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .trig_pins_in, .frame_valid_in, .line_pulse_in,
    .line_trig_pulse_in, .encoder_pulse_in, .acq_req_out, .trig_accept_out
);
`default_nettype wire

// [tb/etq_trig_src.sv]
// Purpose: trigger source and camera frame-valid model
// Assumes: unselected pins carry changing noise
// Notes:   camera makes 20-cycle frames while capture requested
`timescale 1ns/100ps
`default_nettype none
module etq_trig_src (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [15:0] len_in,
    input  wire logic [2:0]  sel_in,
    input  wire logic        high_in,
    input  wire logic        acq_req_in,
    output var  logic [7:0]  trig_pins_out,
    output var  logic        frame_valid_out
);
    typedef struct packed {
        logic [15:0] left;
        logic [7:0]  noise;
        logic [4:0]  ph;
    } etq_src_s;
    etq_src_s st = '{16'h0000, 8'hA5, 5'h00};
    etq_src_s next_st;
    always_comb begin
        next_st = st;
        next_st.noise = {st.noise[6:0], st.noise[7] ^ st.noise[5] ^ st.noise[4] ^ st.noise[3]};
        if (go_in) next_st.left = len_in;
        else if (st.left != 16'h0000) next_st.left = st.left - 16'h0001;
        // frame starts only if still requested after the gap
        if (st.ph == 5'h00) next_st.ph = {4'h0, acq_req_in};
        else if (st.ph == 5'h0B && !acq_req_in) next_st.ph = 5'h00;
        else next_st.ph = st.ph + 5'h01;
        trig_pins_out = st.noise;
        trig_pins_out[sel_in] = (st.left != 16'h0000) ? high_in : !high_in;
        frame_valid_out = st.ph >= 5'h0C;
    end
    always @(posedge clk_in) st <= next_st;
endmodule : etq_trig_src
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench for the trigger qualifier
// Assumes: 200 MHz clock, reset held 4 cycles
// Notes:   reads and frame counts checked against queued notes
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; chk_e = 32'(e); if ((g) !== chk_e) begin fail_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, chk_e); end end
module tb_top;
    logic                      clk_in = 1'b0;
    logic                      reset_in = 1'b1;
    logic                      ce_in = 1'b1;
    logic                      wb_cyc_in = 1'b0;
    logic                      wb_stb_in = 1'b0;
    logic                      wb_we_in = 1'b0;
    logic [7:0]                wb_adr_in = 8'h00;
    logic [3:0]                wb_sel_in = 4'hF;
    logic [31:0]               wb_dat_in = 32'h0000_0000;
    logic [31:0]               wb_dat_out;
    logic                      wb_ack_out;
    logic [etq_pkg::PIN_N-1:0] trig_pins_in;
    logic                      frame_valid_in;
    logic                      line_pulse_in = 1'b0;
    logic                      line_trig_pulse_in = 1'b0;
    logic                      encoder_pulse_in = 1'b0;
    logic                      acq_req_out;
    logic                      trig_accept_out;
    logic                      go = 1'b0;
    logic [15:0]               len = 16'h0000;
    logic [2:0]                sel = 3'h0;
    logic                      high = 1'b1;
    logic                      fv_d = 1'b0;
    logic                      acq_d = 1'b0;
    int                        fail_count = 0;
    int                        n_checks = 0;
    logic [31:0]               chk_e;
    int                        n_acc = 0;
    int                        n_fv = 0;
    logic [31:0]               rd_q[$];
    int                        frm_q[$];
    logic [2:0]  tb_t[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
    logic [31:0] dl_t[5] = '{32'h0000_00C8, 32'h0000_0001, 32'h0000_0003, 32'h0000_0003,
                             32'h0000_0003};
    int          lo_t[5] = '{35, 150, 25, 25, 25};
    int          hi_t[5] = '{46, 215, 40, 40, 40};
    etq_trigger_qualifier etq_trigger_qualifier_i (
        .clk_in, .reset_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .trig_pins_in, .frame_valid_in, .line_pulse_in,
        .line_trig_pulse_in, .encoder_pulse_in, .acq_req_out, .trig_accept_out
    );
    etq_trig_src etq_trig_src_i (
        .clk_in, .go_in(go), .len_in(len), .sel_in(sel), .high_in(high),
        .acq_req_in(acq_req_out), .trig_pins_out(trig_pins_in), .frame_valid_out(frame_valid_in)
    );
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_dat_in <= dat;
        do begin
            @(posedge clk_in);
        end while (wb_ack_out !== 1'b1);
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge clk_in);
    endtask : wb_cycle
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb_cycle(1'b0, adr, 32'h0000_0000);
    endtask : rd
    task automatic arm(input logic [1:0] mode, input logic [2:0] s, input logic hi,
                       input logic [2:0] tbv);
        wb_cycle(1'b1, etq_pkg::ADR_CTRL, 32'h0000_0000);
        sel  <= s;
        high <= hi;
        repeat (8) @(posedge clk_in);
        wb_cycle(1'b1, etq_pkg::ADR_CTRL, 32'({tbv, s, mode, 1'b1}));
    endtask : arm
    task automatic pulse(input logic [15:0] l);
        go  <= 1'b1;
        len <= l;
        @(posedge clk_in);
        go  <= 1'b0;
    endtask : pulse
    task automatic settle();
        while (acq_req_out !== 1'b0) begin
            @(posedge clk_in);
        end
        repeat (40) @(posedge clk_in);
    endtask : settle
    task automatic fire(input logic [15:0] l);
        pulse(l);
        repeat (int'(l) + 30) @(posedge clk_in);
        settle();
    endtask : fire
    // result watcher
    always @(posedge clk_in) begin
        fv_d  <= frame_valid_in;
        acq_d <= acq_req_out;
        if (trig_accept_out === 1'b1) n_acc++;
        if (frame_valid_in && !fv_d) n_fv++;
        if (trig_accept_out === 1'b1) n_fv = 0;
        if (acq_d && !acq_req_out && frm_q.size() != 0) `CHK(n_fv, frm_q.pop_front())
        if (wb_ack_out === 1'b1 && wb_cyc_in && !wb_we_in) `CHK(wb_dat_out, rd_q.pop_front())
    end
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
    initial begin
        int fr;
        int n;
        void'($urandom(70437));
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        rd(etq_pkg::ADR_CTRL, 32'h0000_0000);
        rd(etq_pkg::ADR_MINW, 32'h0000_0000);
        rd(etq_pkg::ADR_FRAMES, 32'h0000_0001);
        rd(etq_pkg::ADR_DELAY, 32'h0000_0000);
        rd(etq_pkg::ADR_IGNORE, 32'h0000_0000);
        rd(8'h1C, 32'h0000_0000);
        fire(16'h0028);
        `CHK(n_acc, 0)
        for (int m = 0; m < 2; m++) begin
            fr = $urandom_range(3, 1);
            wb_cycle(1'b1, etq_pkg::ADR_FRAMES, 32'(fr));
            arm(2'(m), 3'($urandom_range(3)), m == 0, 3'h0);
            frm_q.push_back(fr);
            n_acc = 0;
            fire(16'h0008);
            `CHK(n_acc, 1)
        end
        wb_cycle(1'b1, etq_pkg::ADR_FRAMES, 32'h0000_0000);
        wb_cycle(1'b1, etq_pkg::ADR_FRAMES, 32'hFFFF_FFFF);
        rd(etq_pkg::ADR_FRAMES, 32'(fr));
        rd(etq_pkg::ADR_STATUS, 32'h0000_0101);
        wb_cycle(1'b1, etq_pkg::ADR_FRAMES, etq_pkg::FRAME_MAX);
        rd(etq_pkg::ADR_FRAMES, etq_pkg::FRAME_MAX);
        wb_cycle(1'b1, etq_pkg::ADR_FRAMES, 32'h0000_0001);
        wb_cycle(1'b1, etq_pkg::ADR_MINW, 32'h0000_0002);
        arm(2'h0, 3'h2, 1'b1, 3'h0);
        n_acc = 0;
        fire(16'h012C);
        `CHK(n_acc, 0)
        frm_q.push_back(1);
        fire(16'h01F4);
        `CHK(n_acc, 1)
        wb_cycle(1'b1, etq_pkg::ADR_MINW, 32'h0000_0000);
        for (int k = 0; k < 5; k++) begin
            wb_cycle(1'b1, etq_pkg::ADR_DELAY, dl_t[k]);
            arm(2'h0, 3'h0, 1'b1, tb_t[k]);
            frm_q.push_back(1);
            pulse(16'h0008);
            n = 0;
            while (trig_accept_out !== 1'b1 && n < 100) begin
                @(posedge clk_in);
                n++;
            end
            n = 0;
            while (acq_req_out !== 1'b1 && n < 400) begin
                line_pulse_in      <= tb_t[k] == 3'h3 && n % 10 == 9;
                line_trig_pulse_in <= tb_t[k] == 3'h4 && n % 10 == 9;
                encoder_pulse_in   <= tb_t[k] == 3'h5 && n % 10 == 9;
                @(posedge clk_in);
                n++;
            end
            line_pulse_in      <= 1'b0;
            line_trig_pulse_in <= 1'b0;
            encoder_pulse_in   <= 1'b0;
            `CHK(n >= lo_t[k] && n <= hi_t[k], 1'b1)
            settle();
        end
        wb_cycle(1'b1, etq_pkg::ADR_DELAY, 32'h0000_0000);
        wb_cycle(1'b1, etq_pkg::ADR_IGNORE, 32'h0000_0005);
        arm(2'h0, 3'h0, 1'b1, 3'h0);
        n_acc = 0;
        frm_q.push_back(1);
        fire(16'h0008);
        fire(16'h0008);
        `CHK(n_acc, 1)
        repeat (1200) @(posedge clk_in);
        frm_q.push_back(1);
        fire(16'h0008);
        `CHK(n_acc, 2)
        arm(2'h3, 3'h1, 1'b1, 3'h0);
        pulse(16'h0258);
        repeat (100) begin
            @(posedge clk_in);
            ce_in <= 1'($urandom_range(1));
        end
        ce_in <= 1'b1;
        repeat (200) @(posedge clk_in);
        `CHK(acq_req_out, 1'b1)
        repeat (330) @(posedge clk_in);
        `CHK(acq_req_out, 1'b0)
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
